// ---- rtl/rcts_pkg.sv ----
// rcts_pkg: register map, field layout and shared types of the oscillator trim status block
package rcts_pkg;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] RCTS_OFS_CTRL   = 8'h80;
    localparam logic [7:0] RCTS_OFS_IEN    = 8'h84;
    localparam logic [7:0] RCTS_OFS_STATUS = 8'h88;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int RCTS_BIT_LOCK      = 0;
    localparam int RCTS_BIT_TFAIL     = 1;
    localparam int RCTS_BIT_CLKERR    = 2;
    localparam int RCTS_POS_TARGET    = 0;
    localparam int RCTS_POS_LOOPSEL   = 4;
    localparam int RCTS_POS_RETRY     = 6;

    // ------------------------------------------------------------------
    // values after reset and encodings
    // ------------------------------------------------------------------
    localparam logic [1:0]  RCTS_TARGET_OFF   = 2'h0;
    localparam logic [1:0]  RCTS_TARGET_48M   = 2'h1;
    localparam logic [1:0]  RCTS_RETRY_RST    = 2'h0;
    localparam logic [1:0]  RCTS_LOOPSEL_RST  = 2'h0;
    localparam logic [1:0]  RCTS_IEN_RST      = 2'h0;
    localparam logic [1:0]  RCTS_FLAGS_RST    = 2'h0;
    localparam logic [9:0]  RCTS_RETRY_BASE   = 10'h040;  // 64 loops at select 00
    localparam logic [9:0]  RCTS_CNT_RST      = 10'h000;
    localparam logic [31:0] RCTS_RDATA_RST    = 32'h0000_0000;

    // control register contents
    typedef struct packed {
        logic [1:0] retry_limit_select;
        logic [1:0] loop_select;
        logic [1:0] trim_target_select;
    } rcts_ctrl_t;

    // levels arriving from the oscillator side, synchronised together
    typedef struct packed {
        logic clock_error_detect;
        logic trim_update_toggle;
        logic osc_locked;
    } rcts_osc_t;

endpackage

// ---- rtl/rcts_sync.sv ----
// rcts_sync: three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/100ps
module rcts_sync #(
    parameter int WIDTH = 3
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // asynchronous levels in, filtered levels out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    // ------------------------------------------------------------------
    // per-bit chain
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
            logic s1_reg;
            logic s2_reg;
            logic s3_reg;
            logic q_reg;
            // first stage feeds only the second; agreement filters a late settle
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    s1_reg <= 1'b0;
                    s2_reg <= 1'b0;
                    s3_reg <= 1'b0;
                    q_reg  <= 1'b0;
                end else begin
                    s1_reg <= async_in[gi];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    if (s2_reg == s3_reg) begin
                        q_reg <= s3_reg;
                    end
                end
            end
            assign sync_out[gi] = q_reg;
        end
    endgenerate

endmodule

// ---- rtl/rcts_trim_status.sv ----
// rcts_trim_status: apb register slave with status flags and retry supervision for the rc oscillator trim
`timescale 1ns/100ps
module rcts_trim_status
    import rcts_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // oscillator side levels (foreign domain)
    input  wire logic        clock_error_detect,
    input  wire logic        trim_update_toggle,
    input  wire logic        osc_locked,
    // trim engine control
    output logic             trim_run,
    output logic [1:0]       trim_loop_select,
    // interrupt request
    output logic             irq
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    rcts_ctrl_t  ctrl_reg;
    rcts_ctrl_t  ctrl_next;
    logic [1:0]  ien_reg;                 // [1] clock error, [0] trim fail
    logic [1:0]  ien_next;
    logic        clock_error_flag_reg;
    logic        clock_error_flag_next;
    logic        trim_fail_flag_reg;
    logic        trim_fail_flag_next;
    logic [9:0]  loop_cnt_reg;
    logic [9:0]  loop_cnt_next;
    logic        toggle_seen_reg;
    logic        trim_run_reg;
    logic        irq_reg;
    logic        irq_next;
    logic        pready_reg;
    logic        pslverr_reg;
    logic [31:0] prdata_reg;
    logic [31:0] rdata_mux;

    // ------------------------------------------------------------------
    // synchronise oscillator side levels
    // ------------------------------------------------------------------
    rcts_osc_t osc_async;
    rcts_osc_t osc_sync;

    assign osc_async.clock_error_detect = clock_error_detect;
    assign osc_async.trim_update_toggle = trim_update_toggle;
    assign osc_async.osc_locked         = osc_locked;

    rcts_sync #(
        .WIDTH    ($bits(rcts_osc_t))
    ) u_sync (
        .clk      (clk),
        .rst      (rst),
        .async_in (osc_async),
        .sync_out (osc_sync)
    );

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    wire access_cycle = psel & penable;
    wire xfer_done    = access_cycle & pready_reg;       // the one edge a transfer takes effect
    wire wr_done      = xfer_done & pwrite;
    wire hit_ctrl     = (paddr == RCTS_OFS_CTRL);
    wire hit_ien      = (paddr == RCTS_OFS_IEN);
    wire hit_status   = (paddr == RCTS_OFS_STATUS);
    wire hit_any      = hit_ctrl | hit_ien | hit_status;
    wire wr_ctrl      = wr_done & hit_ctrl;
    wire wr_ien       = wr_done & hit_ien;
    wire wr_status    = wr_done & hit_status;

    // write-one-to-clear strobes; a zero leaves the flag alone
    wire clr_clkerr   = wr_status & pwdata[RCTS_BIT_CLKERR];
    wire clr_tfail    = wr_status & pwdata[RCTS_BIT_TFAIL];

    // ------------------------------------------------------------------
    // trim supervision
    // ------------------------------------------------------------------
    // only select value 01 runs the trim; the other codes are treated as off
    wire trim_enabled = (ctrl_reg.trim_target_select == RCTS_TARGET_48M);

    // retry limit 64 << select: 64, 128, 256, 512
    wire [9:0] retry_limit = RCTS_RETRY_BASE << ctrl_reg.retry_limit_select;

    // each change of the engine's toggle marks one finished trim update
    wire update_evt   = osc_sync.trim_update_toggle ^ toggle_seen_reg;
    wire [9:0] cnt_inc = loop_cnt_reg + 10'h001;
    wire limit_hit    = trim_enabled & update_evt & (cnt_inc == retry_limit)
                        & ~osc_sync.osc_locked;
    wire clkerr_set   = osc_sync.clock_error_detect;

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    // the counter rests at zero while trim is off or locked, so a new run starts fresh
    always_comb begin
        loop_cnt_next = loop_cnt_reg;
        if (!trim_enabled || osc_sync.osc_locked || limit_hit) begin
            loop_cnt_next = RCTS_CNT_RST;
        end else if (update_evt) begin
            loop_cnt_next = cnt_inc;
        end
    end

    // a hardware failure outranks a software write of the target select
    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_ctrl) begin
            ctrl_next.trim_target_select = pwdata[RCTS_POS_TARGET +: 2];
            ctrl_next.loop_select        = pwdata[RCTS_POS_LOOPSEL +: 2];
            ctrl_next.retry_limit_select = pwdata[RCTS_POS_RETRY +: 2];
        end
        if (limit_hit) begin
            ctrl_next.trim_target_select = RCTS_TARGET_OFF;
        end
    end

    assign ien_next = wr_ien ? {pwdata[RCTS_BIT_CLKERR], pwdata[RCTS_BIT_TFAIL]} : ien_reg;

    // set wins over a clear arriving in the same cycle
    assign clock_error_flag_next = clkerr_set | (clock_error_flag_reg & ~clr_clkerr);
    assign trim_fail_flag_next   = limit_hit | (trim_fail_flag_reg & ~clr_tfail);

    // lock indicator is deliberately absent from the request term
    assign irq_next = (clock_error_flag_next & ien_next[1])
                    | (trim_fail_flag_next & ien_next[0]);

    // ------------------------------------------------------------------
    // read data mux
    // ------------------------------------------------------------------
    wire [31:0] rd_ctrl   = {24'h000000, ctrl_reg.retry_limit_select, ctrl_reg.loop_select,
                             2'h0, ctrl_reg.trim_target_select};
    wire [31:0] rd_ien    = {29'h0, ien_reg, 1'b0};
    wire [31:0] rd_status = {29'h0, clock_error_flag_reg, trim_fail_flag_reg,
                             osc_sync.osc_locked};

    always_comb begin
        rdata_mux = RCTS_RDATA_RST;
        if (hit_ctrl) begin
            rdata_mux = rd_ctrl;
        end else if (hit_ien) begin
            rdata_mux = rd_ien;
        end else if (hit_status) begin
            rdata_mux = rd_status;
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    // configuration and flags
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_reg             <= '{RCTS_RETRY_RST, RCTS_LOOPSEL_RST, RCTS_TARGET_OFF};
            ien_reg              <= RCTS_IEN_RST;
            clock_error_flag_reg <= RCTS_FLAGS_RST[0];
            trim_fail_flag_reg   <= RCTS_FLAGS_RST[1];
            irq_reg              <= 1'b0;
        end else begin
            ctrl_reg             <= ctrl_next;
            ien_reg              <= ien_next;
            clock_error_flag_reg <= clock_error_flag_next;
            trim_fail_flag_reg   <= trim_fail_flag_next;
            irq_reg              <= irq_next;
        end
    end

    // retry supervision; run output is dropped the cycle after a failure
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            loop_cnt_reg    <= RCTS_CNT_RST;
            toggle_seen_reg <= 1'b0;
            trim_run_reg    <= 1'b0;
        end else begin
            loop_cnt_reg    <= loop_cnt_next;
            toggle_seen_reg <= osc_sync.trim_update_toggle;
            trim_run_reg    <= (ctrl_next.trim_target_select == RCTS_TARGET_48M);
        end
    end

    // apb answer: one wait state, data captured before the completing edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= RCTS_RDATA_RST;
        end else begin
            pready_reg  <= access_cycle & ~pready_reg;
            pslverr_reg <= access_cycle & ~pready_reg & ~hit_any;
            if (access_cycle && !pready_reg) begin
                prdata_reg <= pwrite ? RCTS_RDATA_RST : rdata_mux;
            end
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign prdata           = prdata_reg;
    assign pready           = pready_reg;
    assign pslverr          = pslverr_reg;
    assign trim_run         = trim_run_reg;
    assign trim_loop_select = ctrl_reg.loop_select;
    assign irq              = irq_reg;

endmodule

// ---- verif/rcts_trim_status_sva.sv ----
// rcts_trim_status_sva: port-level assertions for the oscillator trim status block
`timescale 1ns/100ps
module rcts_trim_status_sva
    import rcts_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // oscillator side and trim engine
    input wire logic        clock_error_detect,
    input wire logic        trim_update_toggle,
    input wire logic        osc_locked,
    input wire logic        trim_run,
    input wire logic [1:0]  trim_loop_select,
    input wire logic        irq
);
    // ------------------------------------------------------------------
    // helper state
    // ------------------------------------------------------------------
    logic [1:0] ien_sh;
    logic       lock_q;
    logic [3:0] lock_age;
    wire        done   = psel && penable && pready;
    wire        mapped = paddr == RCTS_OFS_CTRL || paddr == RCTS_OFS_IEN || paddr == RCTS_OFS_STATUS;
    wire        rd_sts = done && !pwrite && paddr == RCTS_OFS_STATUS;
    wire        wr_ctl = done && pwrite && paddr == RCTS_OFS_CTRL;

    // enables shadowed from bus writes, since irq must be judged from ports alone
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ien_sh <= 2'h0;
            lock_q <= 1'b0;
            lock_age <= 4'h0;
        end else begin
            if (done && pwrite && paddr == RCTS_OFS_IEN) ien_sh <= pwdata[2:1];
            lock_q <= osc_locked;
            lock_age <= (osc_locked != lock_q) ? 4'h0 : (lock_age == 4'hf ? 4'hf : lock_age + 4'h1);
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_first_access;
        psel && penable && !pready && !$past(penable);
    endsequence

    a_ready_wait: assert property (s_first_access |=> pready && psel && penable) else $error("pready late");
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    a_err_decode: assert property (done |-> pslverr == !mapped) else $error("pslverr wrong for address");
    a_err_rdata: assert property (done && pslverr |-> prdata == 32'h0) else $error("unmapped read not zero");
    a_upper_zero: assert property (rd_sts |-> prdata[31:3] == 29'h0) else $error("status upper bits set");
    a_lock_bit: assert property (rd_sts && lock_age > 4'h8 |-> prdata[0] == osc_locked)
        else $error("lock bit does not follow lock");
    // irq is registered from next-state terms, so it lines up with the shadow in the same cycle
    a_irq_masked: assert property (ien_sh == 2'h0 |-> !irq) else $error("irq with enables off");
    a_run_on: assert property (wr_ctl && pwdata[1:0] == RCTS_TARGET_48M |-> ##2 trim_run)
        else $error("trim not running after target on");
    a_run_off: assert property (wr_ctl && pwdata[1:0] != RCTS_TARGET_48M |-> ##2 !trim_run)
        else $error("trim running with target off");
endmodule

bind rcts_trim_status rcts_trim_status_sva u_sva (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clock_error_detect(clock_error_detect), .trim_update_toggle(trim_update_toggle), .osc_locked(osc_locked),
    .trim_run(trim_run), .trim_loop_select(trim_loop_select), .irq(irq));

// ---- verif/rcts_trim_status_tb.sv ----
// rcts_trim_status_tb: self-checking bench for the oscillator trim status block
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
    $display("Error at %0t: got %h expected %h", $time, a, b); end end
module rcts_trim_status_tb
    import rcts_pkg::*;
;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, irq, trim_run;
    logic        clock_error_detect, trim_update_toggle, osc_locked, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  trim_loop_select;
    int          errors, tests_run;

    rcts_trim_status DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .clock_error_detect(clock_error_detect), .trim_update_toggle(trim_update_toggle),
        .osc_locked(osc_locked), .trim_run(trim_run), .trim_loop_select(trim_loop_select), .irq(irq));

    // ------------------------------------------------------------------
    // clock, bus and helper tasks
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // one apb transfer; waits on pready, never on a fixed count
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // eight cycles cover the four-edge synchroniser with margin
    task automatic settle();
        repeat (8) @(posedge clk);
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset_map();
        apb(1'b0, RCTS_OFS_STATUS, 32'h0); `CHK(rd, 32'h0)
        apb(1'b0, 8'h8c, 32'h0); `CHK({err, rd}, {1'b1, 32'h0})
        apb(1'b1, RCTS_OFS_CTRL, 32'h2); settle(); `CHK(trim_run, 1'b0)
    endtask

    task automatic t_lock();
        apb(1'b1, RCTS_OFS_IEN, 32'h6);
        osc_locked <= 1'b1;
        settle();
        apb(1'b0, RCTS_OFS_STATUS, 32'h0); `CHK(rd, 32'h1)
        `CHK(irq, 1'b0)
        osc_locked <= 1'b0;
        settle();
        apb(1'b0, RCTS_OFS_STATUS, 32'h0); `CHK(rd, 32'h0)
        apb(1'b1, RCTS_OFS_IEN, 32'h0);
    endtask

    task automatic t_clock_error();
        clock_error_detect <= 1'b1;
        settle();
        clock_error_detect <= 1'b0;
        settle();
        apb(1'b0, RCTS_OFS_STATUS, 32'h0); `CHK(rd, 32'h4)
        `CHK(irq, 1'b0)
        apb(1'b1, RCTS_OFS_IEN, 32'h4); settle(); `CHK(irq, 1'b1)
        apb(1'b1, RCTS_OFS_STATUS, 32'hffff_fff8);
        apb(1'b0, RCTS_OFS_STATUS, 32'h0); `CHK(rd, 32'h4)
        apb(1'b1, RCTS_OFS_STATUS, 32'h4);
        apb(1'b0, RCTS_OFS_STATUS, 32'h0); `CHK(rd, 32'h0)
        settle(); `CHK(irq, 1'b0)
        apb(1'b1, RCTS_OFS_IEN, 32'h0);
    endtask

    // each retry select: one update short of the limit is no failure, the limit is
    task automatic t_trim_fail();
        logic [31:0] ctl;
        apb(1'b1, RCTS_OFS_IEN, 32'h2);
        for (int s = 0; s < 4; s++) begin
            ctl = (s << 6) | 32'h21;
            apb(1'b1, RCTS_OFS_CTRL, ctl); settle(); `CHK({trim_run, trim_loop_select}, 3'h6)
            for (int i = 1; i < (64 << s); i++) begin
                trim_update_toggle <= ~trim_update_toggle;
                settle();
            end
            apb(1'b0, RCTS_OFS_STATUS, 32'h0); `CHK(rd, 32'h0)
            trim_update_toggle <= ~trim_update_toggle;
            settle();
            apb(1'b0, RCTS_OFS_STATUS, 32'h0); `CHK(rd, 32'h2)
            apb(1'b0, RCTS_OFS_CTRL, 32'h0); `CHK(rd, ctl & 32'hf0)
            `CHK({trim_run, irq}, 2'h1)
            apb(1'b1, RCTS_OFS_STATUS, 32'h2); settle(); `CHK(irq, 1'b0)
        end
        apb(1'b1, RCTS_OFS_IEN, 32'h0);
    endtask

    // ------------------------------------------------------------------
    // verdict, watchdog and main sequence
    // ------------------------------------------------------------------
    task automatic tally_and_finish();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // the run needs about 8000 cycles; this leaves ample margin
    initial begin
        repeat (40000) @(posedge clk);
        errors++;
        tally_and_finish();
    end

    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
        {clock_error_detect, trim_update_toggle, osc_locked} = 3'h0;
        errors = 0;
        tests_run = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_reset_map();
        t_lock();
        t_clock_error();
        t_trim_fail();
        tally_and_finish();
    end
endmodule
